// [verilog/io_param_defines.svh]
// Purpose: Object indices, sub-indices, defaults, limits and timing counts
// Assumes: 25 MHz system clock
// Notes:   Definitions only, no logic
`ifndef IO_PARAM_DEFINES_SVH
`define IO_PARAM_DEFINES_SVH

// Object indices
`define OBJ_JOY_ANALOG     16'h2400
`define OBJ_FW_UPDATE      16'h4554
`define OBJ_DEV_DESC       16'h4555
`define OBJ_SYS_PARAM      16'h4556
`define OBJ_TERM_TEST      16'h4560

// Common and joystick sub-indices
`define SUB_COUNT          8'h00
`define JOY_SUB_AXES       8'h04
`define JOY_SUB_NUM        8'h06
`define JOY_ENTRIES        32'h0000_0006
`define DESC_ENTRIES       32'h0000_000F
`define DESC_LAST_SUB      8'h0F
`define SP_ENTRIES         32'h0000_001E

// System parameter sub-indices
`define SP_SUB_VER         8'h01
`define SP_SUB_TERM        8'h02
`define SP_SUB_BAUD        8'h03
`define SP_SUB_NODE        8'h04
`define SP_SUB_HB          8'h05
`define SP_SUB_LED_FIRST   8'h06
`define SP_SUB_LED_LAST    8'h1D
`define SP_SUB_JOYTYPE     8'h1E
`define SP_VERSION         32'h0000_0000

// Reset defaults
`define DEF_TERM           1'b0
`define DEF_BAUD           2'h1
`define DEF_NODE           8'h29
`define DEF_HB_MS          16'h03E8
`define DEF_DUTY           4'hC
`define DEF_JOYTYPE        1'b0
`define DEF_JOY_COUNT      32'h0000_001A

// Legal ranges
`define BAUD_MAX           32'h0000_0003
`define NODE_MIN           32'h0000_0001
`define NODE_MAX           32'h0000_00FE
`define HB_MIN_MS          32'h0000_00FA
`define HB_MAX_MS          32'h0000_FFFF
`define DUTY_MAX           32'h0000_000F
`define FLAG_MAX           32'h0000_0001

// Axis code and LED modulation
`define AXIS_NEUTRAL       8'h80
`define PWM_LAST_STEP      4'hE

// Heartbeat timebase
`define CLK_FREQ_KHZ       25000
`define HB_TICK_TIME_MS    1
`define HB_TICK_CYCLES     (`CLK_FREQ_KHZ * `HB_TICK_TIME_MS)

`endif

// [verilog/io_param_pkg.sv]
// Purpose: Shared types of the object dictionary bank
// Assumes: Nothing beyond the defines header
// Notes:   Types only
package io_param_pkg;

  // Service data object request
  typedef struct packed {
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } sdo_req_s;

  // Service data object answer
  typedef struct packed {
    logic        abort;
    logic [31:0] data;
  } sdo_resp_s;

  // Non-volatile parameter record
  typedef struct packed {
    logic [7:0]  sub;
    logic [31:0] data;
  } nv_rec_s;

endpackage : io_param_pkg

// [verilog/heartbeat_timer.sv]
// Purpose: Periodic heartbeat strobe at a period in milliseconds
// Assumes: Period input already range checked
// Notes:   A period change applies at once, to the period already in progress
`include "io_param_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module heartbeat_timer #(
  parameter int CYCLES_PER_MS = `HB_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  // Period
  input  wire logic [15:0] period_ms_in,
  // Strobe
  output var  logic        heartbeat_out
);

  if (CYCLES_PER_MS < 1) begin : g_chk
    $error("CYCLES_PER_MS must be at least one");
  end

  logic [31:0] pre_cnt_reg;   // Cycles within one millisecond
  logic [15:0] ms_cnt_reg;    // Milliseconds within one period
  wire         ms_tick  = (pre_cnt_reg == 32'(CYCLES_PER_MS - 1));
  wire         hb_wrap  = ms_tick && (ms_cnt_reg >= (period_ms_in - 16'h0001));

  // Millisecond prescaler
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) pre_cnt_reg <= 32'h0000_0000;
    else           pre_cnt_reg <= ms_tick ? 32'h0000_0000 : pre_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ms_cnt_reg    <= 16'h0000;
      heartbeat_out <= 1'b0;
    end else begin
      heartbeat_out <= hb_wrap;
      if (hb_wrap)      ms_cnt_reg <= 16'h0000;
      else if (ms_tick) ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end

endmodule : heartbeat_timer
`default_nettype wire

// [verilog/io_module_param_objects.sv]
// Purpose: Object dictionary bank of the digital I/O module
// Assumes: One request at a time; answer follows next cycle
// Notes:   Non-volatile store sits outside, behind the commit and restore ports
`include "io_param_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module io_module_param_objects #(
  parameter int                ADC_W         = 8,
  parameter int                NUM_LEDS      = 24,
  parameter logic [31:0]       JOY_COUNT     = `DEF_JOY_COUNT,
  parameter logic [14:0][31:0] DESC_TABLE    = '0,
  parameter int                HB_TICK_CYC   = `HB_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_b_in,
  // Object access request and answer
  input  wire logic                     req_valid_in,
  input  wire io_param_pkg::sdo_req_s   req_in,
  output var  logic                     resp_valid_out,
  output var  io_param_pkg::sdo_resp_s  resp_out,
  // Joystick converter samples, axis 1 lowest
  input  wire logic [3*ADC_W-1:0]       axis_adc_in,
  // LED on states from the LED object
  input  wire logic [NUM_LEDS-1:0]      led_on_in,
  // Non-volatile store
  input  wire logic                     nv_restore_valid_in,
  input  wire io_param_pkg::nv_rec_s    nv_restore_in,
  output var  logic                     nv_commit_valid_out,
  output var  io_param_pkg::nv_rec_s    nv_commit_out,
  // Active settings
  output var  logic                     termination_out,
  output var  logic [1:0]               baud_code_out,
  output var  logic [7:0]               node_id_out,
  output var  logic                     joy_type_out,
  output logic                          heartbeat_out,
  output var  logic [NUM_LEDS-1:0]      led_drive_out
);

  if (ADC_W < 8 || NUM_LEDS != 24) begin : g_chk
    $error("ADC_W below 8 or NUM_LEDS not 24");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [2:0][7:0]          axis_code_reg;   // Quantised axes
  logic [31:0]              axes_word_reg;   // Packed axes readout
  logic                     term_param_reg;  // Persistent termination
  logic                     term_test_reg;   // Volatile termination test
  logic [15:0]              hb_ms_reg;       // Heartbeat period
  logic [NUM_LEDS-1:0][3:0] duty_reg;        // Per-LED duty codes
  logic [3:0]               pwm_cnt_reg;     // Shared modulation step

  ////////////////////////////////////////////////////////////////////////////
  // Parameter range check, used for both master writes and restores
  function automatic logic param_ok(input logic [7:0] s, input logic [31:0] d);
    case (s)
      `SP_SUB_TERM:    param_ok = (d <= `FLAG_MAX);
      `SP_SUB_BAUD:    param_ok = (d <= `BAUD_MAX);
      `SP_SUB_NODE:    param_ok = (d >= `NODE_MIN) && (d <= `NODE_MAX);
      `SP_SUB_HB:      param_ok = (d >= `HB_MIN_MS) && (d <= `HB_MAX_MS);
      `SP_SUB_JOYTYPE: param_ok = (d <= `FLAG_MAX);
      default:         param_ok = (s >= `SP_SUB_LED_FIRST) && (s <= `SP_SUB_LED_LAST)
                                  && (d <= `DUTY_MAX);
    endcase
  endfunction : param_ok

  // Readback of the parameter object
  function automatic logic [31:0] sp_word(input logic [7:0] s);
    case (s)
      `SUB_COUNT:      sp_word = `SP_ENTRIES;
      `SP_SUB_VER:     sp_word = `SP_VERSION;
      `SP_SUB_TERM:    sp_word = {31'h0000_0000, term_param_reg};
      `SP_SUB_BAUD:    sp_word = {30'h0000_0000, baud_code_out};
      `SP_SUB_NODE:    sp_word = {24'h00_0000, node_id_out};
      `SP_SUB_HB:      sp_word = {16'h0000, hb_ms_reg};
      `SP_SUB_JOYTYPE: sp_word = {31'h0000_0000, joy_type_out};
      default:         sp_word = (s >= `SP_SUB_LED_FIRST && s <= `SP_SUB_LED_LAST) ?
                                 {28'h000_0000, duty_reg[5'(s - `SP_SUB_LED_FIRST)]} :
                                 32'h0000_0000;
    endcase
  endfunction : sp_word

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  wire is_wr   = req_valid_in && req_in.write;
  wire is_rd   = req_valid_in && !req_in.write;
  wire obj_joy = (req_in.index == `OBJ_JOY_ANALOG);
  wire obj_dsc = (req_in.index == `OBJ_DEV_DESC);
  wire obj_sp  = (req_in.index == `OBJ_SYS_PARAM);
  wire obj_tt  = (req_in.index == `OBJ_TERM_TEST);
  wire sub0    = (req_in.sub == `SUB_COUNT);

  // readable subs only, count at six
  wire        joy_rd_ok = sub0 || req_in.sub == `JOY_SUB_AXES || req_in.sub == `JOY_SUB_NUM;
  wire [31:0] joy_rd    = sub0 ? `JOY_ENTRIES :
                          (req_in.sub == `JOY_SUB_AXES) ? axes_word_reg : JOY_COUNT;
  wire        dsc_rd_ok = (req_in.sub <= `DESC_LAST_SUB);
  wire [31:0] dsc_rd    = sub0 ? `DESC_ENTRIES : DESC_TABLE[4'(req_in.sub - 8'h01)];
  wire        sp_rd_ok  = (req_in.sub <= `SP_SUB_JOYTYPE);

  // Read selection; firmware update object and unknown objects abort
  wire        rd_ok   = obj_joy ? joy_rd_ok : obj_dsc ? dsc_rd_ok :
                        obj_sp ? sp_rd_ok : (obj_tt && sub0);
  wire [31:0] rd_data = obj_joy ? joy_rd : obj_dsc ? dsc_rd : obj_sp ? sp_word(req_in.sub) :
                        {31'h0000_0000, term_test_reg};

  wire sp_wr_ok = is_wr && obj_sp && param_ok(req_in.sub, req_in.data);
  wire tt_wr_ok = is_wr && obj_tt && sub0 && (req_in.data <= `FLAG_MAX);
  wire abort    = req_in.write ? !(sp_wr_ok || tt_wr_ok) : !rd_ok;

  // Update source: master write wins over a restore in the same cycle
  wire        nv_ok    = nv_restore_valid_in && param_ok(nv_restore_in.sub, nv_restore_in.data);
  wire        upd      = sp_wr_ok || nv_ok;
  wire [7:0]  upd_sub  = sp_wr_ok ? req_in.sub : nv_restore_in.sub;
  wire [31:0] upd_data = sp_wr_ok ? req_in.data : nv_restore_in.data;

  ////////////////////////////////////////////////////////////////////////////
  // Answer, one cycle after the request
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      resp_valid_out <= 1'b0;
      resp_out       <= '0;
    end else begin
      resp_valid_out <= req_valid_in;
      resp_out.abort <= abort;
      resp_out.data  <= (req_in.write || !rd_ok) ? 32'h0000_0000 : rd_data;
    end
  end

  // commit accepted parameter writes; test object never commits
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nv_commit_valid_out <= 1'b0;
      nv_commit_out       <= '0;
    end else begin
      nv_commit_valid_out <= sp_wr_ok;
      if (sp_wr_ok) nv_commit_out <= '{sub: req_in.sub, data: req_in.data};
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      term_param_reg <= `DEF_TERM;
      baud_code_out  <= `DEF_BAUD;
      node_id_out    <= `DEF_NODE;
      hb_ms_reg      <= `DEF_HB_MS;
      joy_type_out   <= `DEF_JOYTYPE;
    end else if (upd) begin
      if (upd_sub == `SP_SUB_TERM)    term_param_reg <= upd_data[0];
      if (upd_sub == `SP_SUB_BAUD)    baud_code_out  <= upd_data[1:0];
      if (upd_sub == `SP_SUB_NODE)    node_id_out    <= upd_data[7:0];
      if (upd_sub == `SP_SUB_HB)      hb_ms_reg      <= upd_data[15:0];
      if (upd_sub == `SP_SUB_JOYTYPE) joy_type_out   <= upd_data[0];
    end
  end

  // test write switches at once, the parameter may switch it back
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      term_test_reg   <= 1'b0;
      termination_out <= `DEF_TERM;
    end else begin
      if (tt_wr_ok) term_test_reg <= req_in.data[0];
      if (tt_wr_ok)                              termination_out <= req_in.data[0];
      else if (upd && upd_sub == `SP_SUB_TERM)   termination_out <= upd_data[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // top eight converter bits give a linear code, centre at 80
  for (genvar a = 0; a < 3; a++) begin : g_axis
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) axis_code_reg[a] <= 8'h00;
      else           axis_code_reg[a] <= axis_adc_in[a*ADC_W+ADC_W-1 -: 8];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) axes_word_reg <= 32'h0000_0000;
    else           axes_word_reg <= {8'h00, axis_code_reg[2], axis_code_reg[1], axis_code_reg[0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fifteen-step modulation, so code 15 is always on and code 0 never
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) pwm_cnt_reg <= 4'h0;
    else           pwm_cnt_reg <= (pwm_cnt_reg == `PWM_LAST_STEP) ? 4'h0 : pwm_cnt_reg + 4'h1;
  end

  for (genvar i = 0; i < NUM_LEDS; i++) begin : g_led
    wire hit = upd && (upd_sub == 8'(`SP_SUB_LED_FIRST + i));
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        duty_reg[i]      <= `DEF_DUTY;
        led_drive_out[i] <= 1'b0;
      end else begin
        if (hit) duty_reg[i] <= upd_data[3:0];
        led_drive_out[i] <= led_on_in[i] && (pwm_cnt_reg < duty_reg[i]);
      end
    end
  end

  heartbeat_timer #(.CYCLES_PER_MS(HB_TICK_CYC)) u_hb (
    .clk_sys_in   (clk_sys_in),
    .rst_b_in     (rst_b_in),
    .period_ms_in (hb_ms_reg),
    .heartbeat_out(heartbeat_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  a_axes_word_read: assert property (
    is_rd && obj_joy && req_in.sub == `JOY_SUB_AXES |=>
      resp_out.data == {8'h00, $past(axes_word_reg[23:0])} && !resp_out.abort)
    else $error("axes word readback wrong");
  a_axis_centre_code: assert property (
    axis_adc_in[ADC_W-1:0] == (ADC_W'(1) << (ADC_W-1)) ##1 1'b1 |=>
      axes_word_reg[7:0] == `AXIS_NEUTRAL)
    else $error("centre input not coded 80");
  a_joy_count_read: assert property (
    is_rd && obj_joy && req_in.sub == `JOY_SUB_NUM |=> resp_out.data == JOY_COUNT)
    else $error("joystick count wrong");
  a_joy_write_abort: assert property (
    is_wr && (obj_joy || obj_dsc || req_in.index == `OBJ_FW_UPDATE) |=>
      resp_valid_out && resp_out.abort && !nv_commit_valid_out)
    else $error("read-only object write not aborted");
  a_desc_count_read: assert property (
    is_rd && obj_dsc && sub0 |=> resp_out.data == `DESC_ENTRIES)
    else $error("description count wrong");
  a_commit_follows: assert property (
    is_wr && obj_sp && !abort |=>
      nv_commit_valid_out && nv_commit_out.sub == $past(req_in.sub) && !resp_out.abort)
    else $error("accepted write not committed");
  a_test_no_commit: assert property (
    tt_wr_ok |=> !nv_commit_valid_out ##1 termination_out == $past(req_in.data[0], 2))
    else $error("test termination committed or not applied");
  a_node_range: assert property (
    node_id_out != 8'h00 && node_id_out != 8'hFF)
    else $error("node identifier out of range");
  a_hb_floor: assert property (
    hb_ms_reg >= 16'(`HB_MIN_MS))
    else $error("heartbeat period below floor");
  a_bad_write_keeps: assert property (
    is_wr && obj_sp && abort && !nv_restore_valid_in |=>
      $stable(node_id_out) && $stable(hb_ms_reg) && $stable(baud_code_out) && resp_out.abort)
    else $error("rejected write changed state");
  a_duty_zero_dark: assert property (
    duty_reg[1] == 4'h0 ##1 duty_reg[1] == 4'h0 |-> !led_drive_out[1])
    else $error("zero duty drives LED");

  c_axes_read:   cover property (is_rd && obj_joy && req_in.sub == `JOY_SUB_AXES);
  c_param_write: cover property (sp_wr_ok && req_in.sub == `SP_SUB_NODE);
  c_bad_write:   cover property (is_wr && obj_sp && abort);
  c_heartbeat:   cover property (heartbeat_out);

endmodule : io_module_param_objects
`default_nettype wire

// [test/bus_master_model.sv]
// Purpose: Network master model issuing object reads and writes
// Assumes: Answer is registered on the same edge that takes the request
// Notes:   Request fields are inverted while idle, so stale values never look valid
`timescale 1ns/100ps
`default_nettype none

module bus_master_model #(
  parameter int GAP = 3  // Idle cycles after a parameter write
) (
  // Clock
  input  wire logic                    clk_sys_in,
  // Request side
  output var  logic                    req_valid_out,
  output var  io_param_pkg::sdo_req_s  req_out,
  // Answer side
  input  wire logic                    resp_valid_in,
  input  wire io_param_pkg::sdo_resp_s resp_in
);
  logic wrote_sys = 1'b0;  // Last access wrote the parameter object

  initial begin
    req_valid_out = 1'b0;
    req_out       = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One access; the answer is taken just after the request edge
  task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] d, output logic rv,
                        output io_param_pkg::sdo_resp_s r);
    rv = 1'b0;
    r  = '0;
    if (wrote_sys) begin
      repeat (GAP) @(posedge clk_sys_in);
    end
    if (idx != 16'h4554) begin
      @(posedge clk_sys_in);
      req_valid_out <= 1'b1;
      req_out       <= {w, idx, sub, d};
      @(posedge clk_sys_in);
      req_valid_out <= 1'b0;
      req_out       <= ~{w, idx, sub, d};
      #1;
      rv        = resp_valid_in;
      r         = resp_in;
      wrote_sys = w && (idx == 16'h4556);
    end
  endtask : access
endmodule : bus_master_model
`default_nettype wire

// [test/tb_io_module_param_objects.sv]
// Purpose: Self-checking bench for the object dictionary bank
// Assumes: Millisecond tick shortened to 4 cycles
// Notes:   Reference settings kept in integers and compared after every parameter write and restore
`include "io_param_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_io_module_param_objects;
  localparam int TICK = 4;  // Short tick keeps heartbeat runs small
  logic                    clk_sys_in = 1'b0;
  logic                    rst_b_in = 1'b0;
  logic                    req_valid_in, resp_valid_out, nv_commit_valid_out;
  io_param_pkg::sdo_req_s  req_in;
  io_param_pkg::sdo_resp_s resp_out, rs;
  logic [23:0]             axis_adc_in = '0, led_on_in = '0, led_drive_out, ax;
  logic                    nv_restore_valid_in = 1'b0;
  io_param_pkg::nv_rec_s   nv_restore_in = '0, nv_commit_out;
  logic                    termination_out, joy_type_out, heartbeat_out, rv;
  logic [1:0]              baud_code_out;
  logic [7:0]              node_id_out;
  int                      err_count = 0, check_count = 0, cyc = 0, seed = 32'h8093;
  int                      r_term, r_baud, r_node, r_jt, n0, n1, n2;  // Reference state
  int ws [] = '{2,2, 2,1, 3,4, 3,0, 3,2, 3,3, 4,0, 4,255, 4,254, 4,1, 5,249, 5,65535,
                5,250, 6,16, 6,15, 7,0, 30,2, 30,1, 1,0, 31,0};

  always #20 clk_sys_in = ~clk_sys_in;

  io_module_param_objects #(.HB_TICK_CYC(TICK)) u_io_module_param_objects (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .resp_valid_out(resp_valid_out), .resp_out(resp_out),
    .axis_adc_in(axis_adc_in), .led_on_in(led_on_in),
    .nv_restore_valid_in(nv_restore_valid_in), .nv_restore_in(nv_restore_in),
    .nv_commit_valid_out(nv_commit_valid_out), .nv_commit_out(nv_commit_out),
    .termination_out(termination_out), .baud_code_out(baud_code_out),
    .node_id_out(node_id_out), .joy_type_out(joy_type_out),
    .heartbeat_out(heartbeat_out), .led_drive_out(led_drive_out));

  bus_master_model u_bus_master_model (
    .clk_sys_in(clk_sys_in), .req_valid_out(req_valid_in), .req_out(req_in),
    .resp_valid_in(resp_valid_out), .resp_in(resp_out));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and hang guard
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // Whole run fits well inside this many cycles
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference model of the parameter ranges
  function automatic logic legal(input int s, input int d);
    case (s)
      2, 30:   legal = d <= 1;
      3:       legal = d <= 3;
      4:       legal = d >= 1 && d <= 254;
      5:       legal = d >= 250 && d <= 65535;
      default: legal = s >= 6 && s <= 29 && d <= 15;
    endcase
  endfunction : legal

  task automatic settings();
    check("termination", {31'h0, termination_out}, r_term);
    check("baud", {30'h0, baud_code_out}, r_baud);
    check("node", {24'h0, node_id_out}, r_node);
    check("joy_type", {31'h0, joy_type_out}, r_jt);
  endtask : settings

  task automatic xfer(input logic w, input logic [15:0] i, input int s, input int d,
                      input logic a, input int exp);
    u_bus_master_model.access(w, i, s[7:0], d, rv, rs);
    check("resp_valid", {31'h0, rv}, 32'h1);
    check("abort", {31'h0, rs.abort}, {31'h0, a});
    check("rdata", rs.data, (a || w) ? 0 : exp);
  endtask : xfer

  // Parameter write, then commit and settings against the reference
  task automatic wp(input int s, input int d);
    logic ok;
    ok = legal(s, d);
    xfer(1'b1, 16'h4556, s, d, !ok, 0);
    check("commit", {31'h0, nv_commit_valid_out}, ok);
    if (ok) begin
      check("commit_sub", {24'h0, nv_commit_out.sub}, s);
      check("commit_data", nv_commit_out.data, d);
      r_term = (s == 2) ? d : r_term;
      r_baud = (s == 3) ? d : r_baud;
      r_node = (s == 4) ? d : r_node;
      r_jt   = (s == 30) ? d : r_jt;
    end
    settings();
  endtask : wp

  task automatic rest(input int s, input int d);
    @(posedge clk_sys_in);
    nv_restore_valid_in <= 1'b1;
    nv_restore_in       <= {8'(s), 32'(d)};
    @(posedge clk_sys_in);
    nv_restore_valid_in <= 1'b0;
    nv_restore_in       <= ~{8'(s), 32'(d)};
    repeat (2) @(posedge clk_sys_in);
    #1;
    if (legal(s, d) && s == 4) r_node = d;
    settings();
  endtask : rest

  task automatic do_reset();
    @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    repeat (12) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    r_term = `DEF_TERM;
    r_baud = `DEF_BAUD;
    r_node = `DEF_NODE;
    r_jt   = `DEF_JOYTYPE;
    @(posedge clk_sys_in);
    #1;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset();
    settings();
    for (int k = 0; k < 4; k++) begin
      ax = (k == 0) ? 24'h00_80FF : (k == 1) ? 24'hFF_0080 : 24'($random(seed));
      @(posedge clk_sys_in);
      axis_adc_in <= ax;
      repeat (3) @(posedge clk_sys_in);
      xfer(1'b0, 16'h2400, 4, 0, 1'b0, {8'h00, ax});
    end
    xfer(1'b0, 16'h2400, 0, 0, 1'b0, 6);
    xfer(1'b0, 16'h2400, 6, 0, 1'b0, 26);
    xfer(1'b1, 16'h2400, 4, 5, 1'b1, 0);
    xfer(1'b0, 16'h2400, 4, 0, 1'b0, {8'h00, ax});
    xfer(1'b0, 16'h4555, 0, 0, 1'b0, 15);
    for (int s = 1; s <= 16; s++) xfer(1'b0, 16'h4555, s, 0, s > 15, 0);
    xfer(1'b1, 16'h4555, 3, 1, 1'b1, 0);
    xfer(1'b0, 16'h4556, 0, 0, 1'b0, 30);
    for (int k = 0; k < ws.size(); k += 2) wp(ws[k], ws[k+1]);
    xfer(1'b0, 16'h4556, 5, 0, 1'b0, 250);
    xfer(1'b0, 16'h4556, 6, 0, 1'b0, 15);
    xfer(1'b0, 16'h4556, 7, 0, 1'b0, 0);
    xfer(1'b0, 16'h4556, 8, 0, 1'b0, 12);
    xfer(1'b0, 16'h4556, 3, 0, 1'b0, 3);
    xfer(1'b0, 16'h4556, 1, 0, 1'b0, 0);
    // LED zero runs full, LED one stays dark, LED two runs at the default 12
    @(posedge clk_sys_in);
    led_on_in <= 24'h00_0007;
    repeat (3) @(posedge clk_sys_in);
    n0 = 0;
    n1 = 0;
    n2 = 0;
    repeat (15) begin
      @(posedge clk_sys_in);
      #1;
      n0 += led_drive_out[0];
      n1 += led_drive_out[1];
      n2 += led_drive_out[2];
    end
    check("led_full", n0, 15);
    check("led_off", n1, 0);
    check("led_default", n2, 12);
    rest(4, 8'h33);
    rest(4, 0);
    xfer(1'b1, 16'h4560, 0, 0, 1'b0, 0);
    check("commit", {31'h0, nv_commit_valid_out}, 0);
    r_term = 0;
    settings();
    xfer(1'b1, 16'h4560, 0, 1, 1'b0, 0);
    check("commit", {31'h0, nv_commit_valid_out}, 0);
    r_term = 1;
    settings();
    xfer(1'b0, 16'h4560, 0, 0, 1'b0, 1);
    xfer(1'b1, 16'h4560, 0, 2, 1'b1, 0);
    // Heartbeat spacing after the new period has taken hold
    n0 = 0;
    while (!heartbeat_out && n0 < 5000) begin
      @(posedge clk_sys_in);
      #1;
      n0++;
    end
    n1 = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      n1++;
    end while (!heartbeat_out && n1 < 5000);
    check("hb_period", n1, 250 * TICK);
    do_reset();
    settings();
    xfer(1'b0, 16'h4560, 0, 0, 1'b0, 0);
    xfer(1'b0, 16'h4556, 5, 0, 1'b0, 1000);
    xfer(1'b0, 16'h4556, 6, 0, 1'b0, 12);
    stop_test();
  end
endmodule : tb_io_module_param_objects
`default_nettype wire
